// >>> design/plrt_pkg.sv
// Constants, register map and state type of the supply-loss ride-through sequencer.
// Assumes a single 25 MHz clock; all rates below are derived from it.
package plrt_pkg;
  // Clock and sequencing times
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int QUAL_MS = 500;
  localparam int QUAL_TICKS = QUAL_MS / TICK_MS;
  localparam int MS_PER_S = 1000;
  localparam int SEC_TICKS = MS_PER_S / TICK_MS;
  localparam int PCT_FULL = 100;
  // Widths
  localparam int DC_W = 16;
  localparam int SPD_W = 24;
  localparam int RATE_W = 16;
  localparam int PCT_W = 8;
  localparam int SEC_W = 16;
  localparam int IRQ_W = 5;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OV_LEVEL = 8'h04;
  localparam logic [7:0] ADDR_TRIP_PCT = 8'h08;
  localparam logic [7:0] ADDR_BAND_PCT = 8'h0C;
  localparam logic [7:0] ADDR_ACC_RATE = 8'h10;
  localparam logic [7:0] ADDR_DEC_RATE = 8'h14;
  localparam logic [7:0] ADDR_TIME_LIM = 8'h18;
  localparam logic [7:0] ADDR_MAIN_ACC = 8'h1C;
  localparam logic [7:0] ADDR_MAIN_DEC = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h28;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h2C;
  localparam logic [7:0] ADDR_SETPOINT = 8'h30;
  // Control fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_FREEZE = 1;
  localparam int CTRL_TRIP_CLR = 2;
  // Interrupt status fields
  localparam int IRQ_START = 0;
  localparam int IRQ_VALID = 1;
  localparam int IRQ_DONE = 2;
  localparam int IRQ_TIMEOUT = 3;
  localparam int IRQ_UV = 4;
  // Reset values
  localparam logic [DC_W-1:0] RST_OV_LEVEL = 16'hFFFF;
  localparam logic [PCT_W-1:0] RST_TRIP_PCT = 8'h46;
  localparam logic [PCT_W-1:0] RST_BAND_PCT = 8'h0A;
  localparam logic [RATE_W-1:0] RST_RATE = 16'h0064;
  localparam logic [SEC_W-1:0] RST_TIME_LIM = 16'h001E;
  // Sequencer states, Gray along idle-decel-hold-accel
  typedef enum logic [1:0] {
    PLRT_IDLE  = 2'b00,
    PLRT_DECEL = 2'b01,
    PLRT_HOLD  = 2'b11,
    PLRT_ACCEL = 2'b10
  } plrt_state_t;
endpackage

// >>> design/plrt_tick_div.sv
// Divider producing the one-cycle millisecond tick enable.
// Assumes the sequencer clock; CYCLES may be shortened for simulation.
`timescale 1ns/1ps
module plrt_tick_div #(
  parameter int CYCLES = 25000
) (
  input wire logic mclk,     // Main clock
  input wire logic rst_b,    // Async reset, active low
  output logic tick_ff       // One-cycle tick pulse
);
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic nxt_tick;

  // Count down and pulse on wrap
  always_comb begin
    nxt_tick = 1'b0;
    nxt_cnt = cnt_ff - 16'h0001;
    if (cnt_ff == 16'h0000) begin
      nxt_cnt = 16'(CYCLES - 1);
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end
endmodule

// >>> design/plrt_core.sv
// Supply-loss ride-through sequencer: compares dc link with trip and band levels,
// ramps the speed setpoint, qualifies supply return and times the sequence.
// Assumes dc link and speed demand come from logic on mclk, so no synchronisers.
`timescale 1ns/1ps

// Function
// (R01) Disabled: never run the sequence; supply loss raises dc undervoltage trip. Enable is only checked in idle; a running sequence continues.
// (R02) Enabled: start sequence when dc link falls below trip percentage of overvoltage.
// (R03) Below threshold plus band, ramp setpoint toward zero at deceleration rate.
// (R04) Above threshold plus band hold setpoint; resume ramp down when it falls again.
// (R05) Supply returned after more than 500 ms above band; setpoint held meanwhile.
// (R06) After validated return, ramp setpoint up to speed demand at acceleration rate.
// (R07) Time sequence in seconds; reaching maximum duration raises timeout trip.
// (R08) Active flag high exactly while the sequence is in progress.
// (R09) Comparisons, timers and ramp steps update once per 1 ms tick.
// (R10) With ramp freeze, applied rates are limited by the main ramp rates.
// (R11) Sequence ends, flag clears and timer resets when setpoint reaches demand.
module plrt_core
  import plrt_pkg::*;
#(
  parameter int TICK_CYCLES_P = plrt_pkg::TICK_CYCLES
) (
  input wire logic mclk,                                  // Main clock, 25 MHz
  input wire logic rst_b,                                 // Async reset, active low
  input wire logic [7:0] reg_addr,                        // Register byte address
  input wire logic [31:0] reg_wdata,                      // Register write data
  input wire logic reg_wr,                                // Write strobe
  input wire logic reg_rd,                                // Read strobe
  output logic [31:0] reg_rdata_ff,                       // Read data, cycle after strobe
  input wire logic [plrt_pkg::DC_W-1:0] dc_link,          // Measured dc link volts
  input wire logic signed [plrt_pkg::SPD_W-1:0] speed_demand, // Demand, mHz
  output logic signed [plrt_pkg::SPD_W-1:0] speed_setpoint_ff, // Ramped setpoint, mHz
  output logic active_ff,                                 // Ride-through in progress
  output logic dc_undervoltage_trip_ff,                   // Latched undervoltage trip
  output logic timeout_trip_ff,                           // Latched supply-loss timeout trip
  output logic irq_ff                                     // Level interrupt
);
  import plrt_pkg::*;

  logic tick;
  logic en_ff, freeze_ff, nxt_en, nxt_freeze;
  logic [DC_W-1:0] ov_ff, nxt_ov;
  logic [PCT_W-1:0] trip_pct_ff, band_pct_ff, nxt_trip_pct, nxt_band_pct;
  logic [RATE_W-1:0] acc_ff, dec_ff, macc_ff, mdec_ff;
  logic [RATE_W-1:0] nxt_acc, nxt_dec, nxt_macc, nxt_mdec;
  logic [SEC_W-1:0] tlim_ff, nxt_tlim;
  logic [IRQ_W-1:0] istat_ff, imask_ff, nxt_istat, nxt_imask, ev;
  logic [31:0] nxt_rdata;
  plrt_state_t state_ff, nxt_state;
  logic signed [SPD_W-1:0] nxt_sp;
  logic [9:0] qual_ff, nxt_qual;
  logic [9:0] ms_ff, nxt_ms;
  logic [SEC_W-1:0] sec_ff, nxt_sec;
  logic nxt_uv, nxt_to, trip_clr;
  logic [25:0] dc_scaled, thr_level, band_level;
  logic [8:0] band_sum;
  logic below_thr, above_band;
  logic [RATE_W-1:0] acc_eff, dec_eff;

  plrt_tick_div #(
    .CYCLES(TICK_CYCLES_P)
  ) u_tick (
    .mclk(mclk),
    .rst_b(rst_b),
    .tick_ff(tick)
  );

  // Levels as percent of overvoltage; scaling dc by 100 avoids a divider
  assign band_sum = {1'b0, trip_pct_ff} + {1'b0, band_pct_ff};
  assign dc_scaled = {10'h000, dc_link} * 26'd100;
  assign thr_level = {18'h00000, trip_pct_ff} * {10'h000, ov_ff}; // see (R02)
  assign band_level = {17'h00000, band_sum} * {10'h000, ov_ff};
  assign below_thr = dc_scaled < thr_level;
  assign above_band = dc_scaled > band_level;

  // Ramp freeze caps the rates at the main ramp's rates
  assign acc_eff = (freeze_ff && macc_ff < acc_ff) ? macc_ff : acc_ff; // see (R10)
  assign dec_eff = (freeze_ff && mdec_ff < dec_ff) ? mdec_ff : dec_ff; // see (R10)

  // One tick step of at most step mHz toward target
  function automatic logic signed [SPD_W-1:0] step_to(
    input logic signed [SPD_W-1:0] cur,
    input logic signed [SPD_W-1:0] target,
    input logic [RATE_W-1:0] step
  );
    logic signed [SPD_W:0] d;
    logic signed [SPD_W:0] s;
    d = {target[SPD_W-1], target} - {cur[SPD_W-1], cur};
    s = $signed({9'h000, step});
    if (d > s) begin
      step_to = cur + s[SPD_W-1:0];
    end else if (d < -s) begin
      step_to = cur - s[SPD_W-1:0];
    end else begin
      step_to = target;
    end
  endfunction

  // Sequencer next state, setpoint, timers and trips
  always_comb begin
    nxt_state = state_ff;
    nxt_sp = speed_setpoint_ff;
    nxt_qual = qual_ff;
    nxt_ms = ms_ff;
    nxt_sec = sec_ff;
    nxt_uv = dc_undervoltage_trip_ff;
    nxt_to = timeout_trip_ff;
    ev = '0;
    if (tick) begin // see (R09)
      case (state_ff)
        PLRT_IDLE: begin
          nxt_sp = (nxt_uv || nxt_to) ? '0 : speed_demand;
          if (below_thr && !en_ff) begin
            nxt_uv = 1'b1; // see (R01)
            ev[IRQ_UV] = !dc_undervoltage_trip_ff;
          end else if (below_thr && !dc_undervoltage_trip_ff && !timeout_trip_ff) begin
            nxt_state = PLRT_DECEL; // see (R02)
            nxt_sp = speed_setpoint_ff;
            ev[IRQ_START] = 1'b1;
          end
        end
        PLRT_DECEL: begin
          nxt_sp = step_to(speed_setpoint_ff, '0, dec_eff); // see (R03)
          if (above_band) begin
            nxt_state = PLRT_HOLD; // see (R04)
            nxt_sp = speed_setpoint_ff;
            nxt_qual = '0;
          end
        end
        PLRT_HOLD: begin
          if (!above_band) begin
            nxt_state = PLRT_DECEL; // see (R04)
          end else if (qual_ff == 10'(QUAL_TICKS)) begin
            nxt_state = PLRT_ACCEL; // see (R05)
            ev[IRQ_VALID] = 1'b1;
          end else begin
            nxt_qual = qual_ff + 10'h001; // see (R05)
          end
        end
        PLRT_ACCEL: begin
          nxt_sp = step_to(speed_setpoint_ff, speed_demand, acc_eff); // see (R06)
          if (below_thr) begin
            nxt_state = PLRT_DECEL;
            nxt_sp = speed_setpoint_ff;
          end else if (nxt_sp == speed_demand) begin
            nxt_state = PLRT_IDLE; // see (R11)
            ev[IRQ_DONE] = 1'b1;
          end
        end
        default: nxt_state = PLRT_IDLE;
      endcase
      // Sequence clock in whole seconds
      if (state_ff != PLRT_IDLE) begin
        if (ms_ff == 10'(SEC_TICKS - 1)) begin
          nxt_ms = '0;
          nxt_sec = sec_ff + 16'h0001; // see (R07)
        end else begin
          nxt_ms = ms_ff + 10'h001;
        end
        if (sec_ff >= tlim_ff) begin
          nxt_state = PLRT_IDLE; // see (R07)
          nxt_sp = '0;
          nxt_to = 1'b1;
          ev = '0;
          ev[IRQ_TIMEOUT] = 1'b1;
        end
      end
      if (nxt_state == PLRT_IDLE) begin
        nxt_ms = '0; // see (R11)
        nxt_sec = '0;
        nxt_qual = '0;
      end
    end
    // A trip raised this cycle survives a simultaneous clear
    if (trip_clr) begin
      nxt_uv = nxt_uv && !dc_undervoltage_trip_ff;
      nxt_to = nxt_to && !timeout_trip_ff;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= PLRT_IDLE;
      speed_setpoint_ff <= '0;
      qual_ff <= '0;
      ms_ff <= '0;
      sec_ff <= '0;
      dc_undervoltage_trip_ff <= 1'b0;
      timeout_trip_ff <= 1'b0;
      active_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      speed_setpoint_ff <= nxt_sp;
      qual_ff <= nxt_qual;
      ms_ff <= nxt_ms;
      sec_ff <= nxt_sec;
      dc_undervoltage_trip_ff <= nxt_uv;
      timeout_trip_ff <= nxt_to;
      active_ff <= (nxt_state != PLRT_IDLE); // see (R08)
    end
  end

  // Register writes; interrupt set wins over write-one clear
  assign trip_clr = reg_wr && (reg_addr == ADDR_CTRL) && reg_wdata[CTRL_TRIP_CLR];
  always_comb begin
    nxt_en = en_ff;
    nxt_freeze = freeze_ff;
    nxt_ov = ov_ff;
    nxt_trip_pct = trip_pct_ff;
    nxt_band_pct = band_pct_ff;
    nxt_acc = acc_ff;
    nxt_dec = dec_ff;
    nxt_macc = macc_ff;
    nxt_mdec = mdec_ff;
    nxt_tlim = tlim_ff;
    nxt_imask = imask_ff;
    nxt_istat = istat_ff | ev;
    if (reg_wr) begin
      if (reg_addr == ADDR_CTRL) begin
        nxt_en = reg_wdata[CTRL_EN];
        nxt_freeze = reg_wdata[CTRL_FREEZE];
      end else if (reg_addr == ADDR_OV_LEVEL) begin
        nxt_ov = reg_wdata[DC_W-1:0];
      end else if (reg_addr == ADDR_TRIP_PCT) begin
        nxt_trip_pct = reg_wdata[PCT_W-1:0];
      end else if (reg_addr == ADDR_BAND_PCT) begin
        nxt_band_pct = reg_wdata[PCT_W-1:0];
      end else if (reg_addr == ADDR_ACC_RATE) begin
        nxt_acc = reg_wdata[RATE_W-1:0];
      end else if (reg_addr == ADDR_DEC_RATE) begin
        nxt_dec = reg_wdata[RATE_W-1:0];
      end else if (reg_addr == ADDR_TIME_LIM) begin
        nxt_tlim = reg_wdata[SEC_W-1:0];
      end else if (reg_addr == ADDR_MAIN_ACC) begin
        nxt_macc = reg_wdata[RATE_W-1:0];
      end else if (reg_addr == ADDR_MAIN_DEC) begin
        nxt_mdec = reg_wdata[RATE_W-1:0];
      end else if (reg_addr == ADDR_IRQ_STAT) begin
        nxt_istat = (istat_ff & ~reg_wdata[IRQ_W-1:0]) | ev;
      end else if (reg_addr == ADDR_IRQ_MASK) begin
        nxt_imask = reg_wdata[IRQ_W-1:0];
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    nxt_rdata = '0;
    if (reg_rd) begin
      if (reg_addr == ADDR_CTRL) begin
        nxt_rdata = {30'h00000000, freeze_ff, en_ff};
      end else if (reg_addr == ADDR_OV_LEVEL) begin
        nxt_rdata = {16'h0000, ov_ff};
      end else if (reg_addr == ADDR_TRIP_PCT) begin
        nxt_rdata = {24'h000000, trip_pct_ff};
      end else if (reg_addr == ADDR_BAND_PCT) begin
        nxt_rdata = {24'h000000, band_pct_ff};
      end else if (reg_addr == ADDR_ACC_RATE) begin
        nxt_rdata = {16'h0000, acc_ff};
      end else if (reg_addr == ADDR_DEC_RATE) begin
        nxt_rdata = {16'h0000, dec_ff};
      end else if (reg_addr == ADDR_TIME_LIM) begin
        nxt_rdata = {16'h0000, tlim_ff};
      end else if (reg_addr == ADDR_MAIN_ACC) begin
        nxt_rdata = {16'h0000, macc_ff};
      end else if (reg_addr == ADDR_MAIN_DEC) begin
        nxt_rdata = {16'h0000, mdec_ff};
      end else if (reg_addr == ADDR_STATUS) begin
        nxt_rdata = {sec_ff, 11'h000, timeout_trip_ff, dc_undervoltage_trip_ff,
                     state_ff, active_ff};
      end else if (reg_addr == ADDR_IRQ_STAT) begin
        nxt_rdata = {27'h0000000, istat_ff};
      end else if (reg_addr == ADDR_IRQ_MASK) begin
        nxt_rdata = {27'h0000000, imask_ff};
      end else if (reg_addr == ADDR_SETPOINT) begin
        nxt_rdata = {{8{speed_setpoint_ff[SPD_W-1]}}, speed_setpoint_ff};
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      en_ff <= 1'b0;
      freeze_ff <= 1'b0;
      ov_ff <= RST_OV_LEVEL;
      trip_pct_ff <= RST_TRIP_PCT;
      band_pct_ff <= RST_BAND_PCT;
      acc_ff <= RST_RATE;
      dec_ff <= RST_RATE;
      macc_ff <= RST_RATE;
      mdec_ff <= RST_RATE;
      tlim_ff <= RST_TIME_LIM;
      istat_ff <= '0;
      imask_ff <= '0;
      reg_rdata_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      en_ff <= nxt_en;
      freeze_ff <= nxt_freeze;
      ov_ff <= nxt_ov;
      trip_pct_ff <= nxt_trip_pct;
      band_pct_ff <= nxt_band_pct;
      acc_ff <= nxt_acc;
      dec_ff <= nxt_dec;
      macc_ff <= nxt_macc;
      mdec_ff <= nxt_mdec;
      tlim_ff <= nxt_tlim;
      istat_ff <= nxt_istat;
      imask_ff <= nxt_imask;
      reg_rdata_ff <= nxt_rdata;
      irq_ff <= |(nxt_istat & nxt_imask);
    end
  end

  // Checks on the sequencer
  a_disabled_idle: assert property (@(posedge mclk) disable iff (!rst_b) // see (R01)
    (state_ff == PLRT_IDLE && !en_ff && tick && below_thr) |=> dc_undervoltage_trip_ff
      && !active_ff) else $error("disabled supply loss did not trip");
  a_start_seq: assert property (@(posedge mclk) disable iff (!rst_b) // see (R02)
    (state_ff == PLRT_IDLE && en_ff && tick && below_thr && !dc_undervoltage_trip_ff
      && !timeout_trip_ff) |=> state_ff == PLRT_DECEL) else $error("sequence did not start");
  a_decel_step: assert property (@(posedge mclk) disable iff (!rst_b) // see (R03)
    (state_ff == PLRT_DECEL && tick && !above_band && sec_ff < tlim_ff
      && speed_setpoint_ff > $signed({9'h000, dec_eff}))
      |=> speed_setpoint_ff == $past(speed_setpoint_ff) - $signed({9'h000, $past(dec_eff)}))
    else $error("decel step wrong");
  a_hold_still: assert property (@(posedge mclk) disable iff (!rst_b) // see (R05)
    (state_ff == PLRT_HOLD) |=> (state_ff != PLRT_HOLD) || $stable(speed_setpoint_ff))
    else $error("setpoint moved while held");
  a_qual_count: assert property (@(posedge mclk) disable iff (!rst_b) // see (R05)
    $rose(state_ff == PLRT_ACCEL) |-> $past(state_ff) == PLRT_HOLD
      && $past(qual_ff) == 10'(QUAL_TICKS)) else $error("return validated too early");
  a_no_tick_move: assert property (@(posedge mclk) disable iff (!rst_b) // see (R09)
    !tick |=> $stable(state_ff) && $stable(sec_ff)) else $error("update without tick");
  a_timeout: assert property (@(posedge mclk) disable iff (!rst_b) // see (R07)
    (state_ff != PLRT_IDLE && tick && sec_ff >= tlim_ff) |=> timeout_trip_ff
      && state_ff == PLRT_IDLE) else $error("timeout trip missing");
  a_active_flag: assert property (@(posedge mclk) disable iff (!rst_b) // see (R08)
    active_ff == (state_ff != PLRT_IDLE)) else $error("active flag mismatch");
  a_freeze_cap: assert property (@(posedge mclk) disable iff (!rst_b) // see (R10)
    freeze_ff |-> acc_eff <= macc_ff && dec_eff <= mdec_ff) else $error("rate not capped");
  a_done_reset: assert property (@(posedge mclk) disable iff (!rst_b) // see (R11)
    (state_ff == PLRT_ACCEL ##1 state_ff == PLRT_IDLE && !timeout_trip_ff)
      |-> speed_setpoint_ff == $past(speed_demand) && sec_ff == '0)
    else $error("sequence end wrong");
  c_ride_through: cover property (@(posedge mclk) disable iff (!rst_b)
    state_ff == PLRT_ACCEL ##1 state_ff == PLRT_IDLE);
  c_redecel: cover property (@(posedge mclk) disable iff (!rst_b)
    state_ff == PLRT_HOLD ##1 state_ff == PLRT_DECEL);
  c_timeout: cover property (@(posedge mclk) disable iff (!rst_b) $rose(timeout_trip_ff));
  c_uv_trip: cover property (@(posedge mclk) disable iff (!rst_b)
    $rose(dc_undervoltage_trip_ff));
endmodule

// >>> tb/plrt_supply_model.sv
// Far-side model: dc link measurement that slews toward a commanded level.
// Assumes the bench commands the level on mclk; speed demand comes from the bench.
`timescale 1ns/1ps
module plrt_supply_model
  import plrt_pkg::*;
#(
  parameter int SLEW = 50
) (
  input wire logic mclk,                         // Main clock
  input wire logic rst_b,                        // Async reset, active low
  input wire logic [plrt_pkg::DC_W-1:0] dc_cmd,  // Commanded link level
  output logic [plrt_pkg::DC_W-1:0] dc_link      // Measured link level
);
  // Finite slew, like a real link capacitor, so edges larger than SLEW are never ideal
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dc_link <= dc_cmd;
    end else if (dc_link + SLEW[DC_W-1:0] < dc_cmd) begin
      dc_link <= dc_link + SLEW[DC_W-1:0];
    end else if (dc_link > dc_cmd + SLEW[DC_W-1:0]) begin
      dc_link <= dc_link - SLEW[DC_W-1:0];
    end else begin
      dc_link <= dc_cmd;
    end
  end
endmodule

// >>> tb/tb.sv
// Self-checking bench for the ride-through sequencer with a shortened tick.
// Assumes the supply model in tb/ and the design package and core in design/.
`timescale 1ns/1ps
module tb;
  import plrt_pkg::*;
  localparam int TK = 20;
  logic mclk, rst_b, reg_wr, reg_rd, rd_d;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_ff, rv, ck_m;
  logic [DC_W-1:0] dc_link, dc_cmd;
  logic signed [SPD_W-1:0] speed_demand, speed_setpoint_ff, v;
  logic active_ff, dc_undervoltage_trip_ff, timeout_trip_ff, irq_ff;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int n_errors, n_compared, cyc, n;
  plrt_core #(.TICK_CYCLES_P(TK)) DUT (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .dc_link(dc_link), .speed_demand(speed_demand), .speed_setpoint_ff(speed_setpoint_ff),
    .active_ff(active_ff), .dc_undervoltage_trip_ff(dc_undervoltage_trip_ff),
    .timeout_trip_ff(timeout_trip_ff), .irq_ff(irq_ff));
  plrt_supply_model SUP (.mclk(mclk), .rst_b(rst_b), .dc_cmd(dc_cmd), .dc_link(dc_link));
  // Clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    n_compared++;
    if (got !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  task automatic chk_spd(input logic signed [SPD_W-1:0] got, input logic signed [SPD_W-1:0] e);
    n_compared++;
    if (got !== e) begin
      n_errors++;
      $display("Error at %0t: setpoint %h expected %h", $time, got, e);
    end
  endtask
  task automatic end_of_test;
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Expected read data is queued before the strobe goes out
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  task automatic set_in(input logic [DC_W-1:0] dc, input logic signed [SPD_W-1:0] dem);
    @(posedge mclk);
    dc_cmd <= dc;
    speed_demand <= dem;
  endtask
  // Counts settled cycles until the setpoint moves, bounded
  task automatic wait_chg(input int lim, output int k);
    logic signed [SPD_W-1:0] s;
    s = speed_setpoint_ff;
    k = 0;
    while (speed_setpoint_ff === s && k < lim) begin
      @(negedge mclk);
      k++;
    end
  endtask
  task automatic step_chk(input logic signed [SPD_W-1:0] st);
    logic signed [SPD_W-1:0] s0;
    int k;
    wait_chg(3 * TK, k);
    s0 = speed_setpoint_ff;
    wait_chg(3 * TK, k);
    chk(32'(k), 32'(TK));
    chk_spd(speed_setpoint_ff, s0 + st);
  endtask
  // Read data stands only in the cycle after the strobe, zero otherwise
  // Own mask variable: the stimulus process owns rv; skipped in reset, where it may be unknown
  always @(posedge mclk) begin
    if (rd_d === 1'b1) begin
      ck_m = msk_q.pop_front();
      chk(reg_rdata_ff & ck_m, exp_q.pop_front() & ck_m);
    end else if (rst_b === 1'b1) begin
      chk(reg_rdata_ff, 32'h0);
    end
    rd_d <= reg_rd;
  end
  // Watchdog sized for about 33k cycles of work
  always @(posedge mclk) begin
    cyc++;
    if (cyc >= 60000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_d = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    dc_cmd = 16'h0384;
    speed_demand = 24'sd5000;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    void'($urandom(79388));
    // Reset values, then an unmapped place
    rd(ADDR_CTRL, 32'h0, 32'hFFFFFFFF);
    rd(ADDR_OV_LEVEL, 32'h0000FFFF, 32'hFFFFFFFF);
    rd(ADDR_TRIP_PCT, 32'h00000046, 32'hFFFFFFFF);
    rd(ADDR_BAND_PCT, 32'h0000000A, 32'hFFFFFFFF);
    rd(ADDR_ACC_RATE, 32'h00000064, 32'hFFFFFFFF);
    rd(ADDR_DEC_RATE, 32'h00000064, 32'hFFFFFFFF);
    rd(ADDR_TIME_LIM, 32'h0000001E, 32'hFFFFFFFF);
    rd(ADDR_MAIN_ACC, 32'h00000064, 32'hFFFFFFFF);
    rd(ADDR_MAIN_DEC, 32'h00000064, 32'hFFFFFFFF);
    rd(ADDR_IRQ_MASK, 32'h0, 32'hFFFFFFFF);
    rd(8'h3C, 32'h0, 32'hFFFFFFFF);
    // Random word: only the low 16 bits are kept
    rv = $urandom();
    wr(ADDR_ACC_RATE, rv);
    rd(ADDR_ACC_RATE, {16'h0000, rv[15:0]}, 32'hFFFFFFFF);
    // Threshold 700, band top 800 counts
    wr(ADDR_OV_LEVEL, 32'h000003E8);
    // Small enough that the climb back from 4500 takes four full steps
    wr(ADDR_ACC_RATE, 32'h00000078);
    wr(ADDR_MAIN_DEC, 32'h00000032);
    wr(ADDR_TIME_LIM, 32'h00000001);
    wr(ADDR_IRQ_MASK, 32'h00000001);
    // Disabled from reset below the default threshold, so the trip is latched: clear it
    wr(ADDR_CTRL, 32'h00000005);
    repeat (3 * TK) @(negedge mclk);
    chk_spd(speed_setpoint_ff, 24'sd5000);
    rd(ADDR_SETPOINT, 32'd5000, 32'hFFFFFFFF);
    chk(32'(irq_ff), 32'h0);
    // Supply loss starts the sequence
    set_in(16'h0258, 24'sd5000);
    n = 0;
    while (active_ff !== 1'b1 && n < 3 * TK) begin
      @(negedge mclk);
      n++;
    end
    chk(32'(active_ff), 32'h1);
    chk(32'(irq_ff), 32'h1);
    wr(ADDR_IRQ_STAT, 32'h00000001);
    @(negedge mclk);
    chk(32'(irq_ff), 32'h0);
    rd(ADDR_STATUS, 32'h3, 32'h7);
    step_chk(-24'sd100);
    wr(ADDR_CTRL, 32'h00000003);
    step_chk(-24'sd50);
    wr(ADDR_CTRL, 32'h00000001);
    // Recovery above band freezes the setpoint, a new fall resumes the ramp
    set_in(16'h0352, 24'sd5000);
    repeat (2 * TK) @(negedge mclk);
    v = speed_setpoint_ff;
    repeat (100 * TK) @(negedge mclk);
    chk_spd(speed_setpoint_ff, v);
    rd(ADDR_STATUS, 32'h7, 32'h7);
    set_in(16'h0258, 24'sd5000);
    step_chk(-24'sd100);
    // Qualification must exceed 500 ticks, then ramp up
    set_in(16'h0352, 24'sd5000);
    repeat (2 * TK) @(negedge mclk);
    v = speed_setpoint_ff;
    wait_chg(600 * TK, n);
    n = n + 2 * TK;
    chk(32'(n >= 501 * TK && n <= 504 * TK), 32'h1);
    chk(32'(speed_setpoint_ff > v), 32'h1);
    step_chk(24'sd120);
    n = 0;
    while (active_ff !== 1'b0 && n < 40 * TK) begin
      @(negedge mclk);
      n++;
    end
    chk_spd(speed_setpoint_ff, 24'sd5000);
    rd(ADDR_STATUS, 32'h0, 32'hFFFF0007);
    // Endless loss runs into the time limit; start is masked this time
    wr(ADDR_IRQ_STAT, 32'h0000001F);
    wr(ADDR_IRQ_MASK, 32'h00000008);
    set_in(16'h0258, 24'sd5000);
    n = 0;
    while (active_ff !== 1'b1 && n < 3 * TK) begin
      @(negedge mclk);
      n++;
    end
    chk(32'(irq_ff), 32'h0);
    n = 0;
    while (timeout_trip_ff !== 1'b1 && n < 1100 * TK) begin
      @(negedge mclk);
      n++;
    end
    chk(32'(n >= 999 * TK && n <= 1003 * TK), 32'h1);
    chk(32'(active_ff), 32'h0);
    chk_spd(speed_setpoint_ff, 24'sd0);
    chk(32'(irq_ff), 32'h1);
    set_in(16'h0384, 24'sd5000);
    wr(ADDR_CTRL, 32'h00000005);
    wr(ADDR_IRQ_STAT, 32'h0000001F);
    @(negedge mclk);
    chk(32'(timeout_trip_ff), 32'h0);
    chk(32'(irq_ff), 32'h0);
    // Disabled: loss trips on undervoltage, no sequence
    wr(ADDR_CTRL, 32'h00000000);
    set_in(16'h0258, 24'sd5000);
    repeat (3 * TK) @(negedge mclk);
    chk(32'(dc_undervoltage_trip_ff), 32'h1);
    chk(32'(active_ff), 32'h0);
    rd(ADDR_STATUS, 32'h08, 32'h19);
    repeat (4) @(posedge mclk);
    end_of_test();
  end
endmodule
